// >>> rtl/audio_port_map.svh
`ifndef AUDIO_PORT_MAP_SVH
`define AUDIO_PORT_MAP_SVH
// ==========================================
// timing
`define AP_CLK_KHZ 100000
`define AP_I2S_BCLK_KHZ 256
`define AP_SLAVE_BCLK_MAX_KHZ 3072
// divider adds N per cycle, toggles the bit clock each time it passes M
`define AP_DIV_N_RST 16'(2 * `AP_I2S_BCLK_KHZ / 16)
`define AP_DIV_M_RST 16'(`AP_CLK_KHZ / 16)
// ==========================================
// register byte addresses
`define AP_CTRL 8'h00
`define AP_SLOT 8'h04
`define AP_DIV 8'h08
`define AP_STAT 8'h0c
`define AP_TXL 8'h10
`define AP_TXR 8'h14
`define AP_RXL 8'h18
`define AP_RXR 8'h1c
`define AP_PTX0 8'h20
`define AP_PTX1 8'h24
`define AP_PTX2 8'h28
`define AP_PRX0 8'h30
`define AP_PRX1 8'h34
`define AP_PRX2 8'h38
// ==========================================
// reset values
`define AP_CTRL_RST 17'h00000
`define AP_SLOT_RST 12'h210
`endif

// >>> rtl/audio_port_pkg.sv
`default_nettype none
package audio_port_pkg;
  typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_VALUE} fill_e;
  // control word, enable in bit 0
  typedef struct packed {
    logic [2:0] chEn;
    logic [2:0] slotsLog;
    logic lsbFirst;
    logic rightJust;
    logic [2:0] fillVal;
    fill_e fill;
    logic longSync;
    logic master;
    logic pcm;
    logic enable;
  } ctrl_s;
endpackage
`default_nettype wire

// >>> rtl/audio_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_map.svh"
module audio_serial_port (
  input wire logic clk, // 100 MHz
  input wire logic rst_n, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic sckIn, // bit clock pin in
  output logic sckOut, // bit clock pin out
  output logic sckOe, // bit clock drive
  input wire logic wsIn, // word select or sync in
  output logic wsOut, // word select or sync out
  output logic wsOe, // word select drive
  input wire logic diIn, // serial data in
  output logic doOut, // serial data out
  output logic doOe // serial data drive
);
  import audio_port_pkg::*;

  ctrl_s ctrl_ff;
  logic [11:0] slotMap_ff;
  logic [15:0] divN_ff, divM_ff, divAcc_ff, txL_ff, txR_ff, rxL_ff, rxR_ff;
  logic [15:0] txSh_ff, rxSh_ff;
  logic [12:0] pcmTx_ff [3];
  logic [12:0] pcmRx_ff [3];
  logic [31:0] prdata_ff, rdVal;
  logic pready_ff, pslverr_ff, hit, accWr, setupRd;
  logic sckS1_ff, sckS2_ff, sckS3_ff, wsS1_ff, wsS2_ff, diS1_ff, diS2_ff;
  logic sckGen_ff, wsGen_ff, sckOe_ff, wsOe_ff, doOut_ff, doOe_ff;
  logic wsR_ff, wsR2_ff, syncF_ff, startSeen_ff, locked_ff;
  logic [3:0] i2sCnt_ff;
  logic [7:0] bitIdx_ff, top, newIdx;
  logic [16:0] divSum;
  logic divTick, run, sckRise, sckFall, syncLvl, di;
  logic [2:0] hitNew, hitCur;
  logic [15:0] i2sWord, pcmWord;

  // ==========================================
  // helpers
  function automatic logic [7:0] frameTop(input logic [2:0] lg);
    case (lg)
      3'h0: frameTop = 8'h0f;
      3'h1: frameTop = 8'h1f;
      3'h2: frameTop = 8'h3f;
      3'h3: frameTop = 8'h7f;
      default: frameTop = 8'hff;
    endcase
  endfunction

  // lowest channel wins if two share a slot
  function automatic logic [2:0] chHit(input logic [3:0] slot, input logic [2:0] en,
                                       input logic [11:0] map);
    chHit = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && map[4*i +: 4] == slot) chHit = {1'b1, 2'(i)};
    end
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = w[15-i];
    end
  endfunction

  function automatic logic [15:0] fmtTx(input logic [12:0] s, input ctrl_s c);
    logic [2:0] f;
    logic [15:0] w;
    case (c.fill)
      FILL_ZERO: f = 3'h0;
      FILL_ONE: f = 3'h7;
      FILL_SIGN: f = {3{s[12]}};
      default: f = c.fillVal;
    endcase
    w = c.rightJust ? {f, s} : {s, f};
    fmtTx = c.lsbFirst ? rev16(w) : w;
  endfunction

  function automatic logic [12:0] fmtRx(input logic [15:0] w, input ctrl_s c);
    logic [15:0] v;
    v = c.lsbFirst ? rev16(w) : w;
    fmtRx = c.rightJust ? v[12:0] : v[15:3];
  endfunction

  // ==========================================
  // apb slave, one wait state
  assign accWr = psel && penable && pready_ff && pwrite;
  assign setupRd = psel && penable && !pready_ff;

  always_comb begin
    hit = 1'b1;
    rdVal = 32'h0;
    case (paddr)
      `AP_CTRL: rdVal = 32'(ctrl_ff);
      `AP_SLOT: rdVal = {20'h0, slotMap_ff};
      `AP_DIV: rdVal = {divM_ff, divN_ff};
      `AP_STAT: rdVal = {21'h0, locked_ff, syncLvl, doOe_ff, bitIdx_ff};
      `AP_TXL: rdVal = {16'h0, txL_ff};
      `AP_TXR: rdVal = {16'h0, txR_ff};
      `AP_RXL: rdVal = {16'h0, rxL_ff};
      `AP_RXR: rdVal = {16'h0, rxR_ff};
      `AP_PTX0: rdVal = {19'h0, pcmTx_ff[0]};
      `AP_PTX1: rdVal = {19'h0, pcmTx_ff[1]};
      `AP_PTX2: rdVal = {19'h0, pcmTx_ff[2]};
      `AP_PRX0: rdVal = {19'h0, pcmRx_ff[0]};
      `AP_PRX1: rdVal = {19'h0, pcmRx_ff[1]};
      `AP_PRX2: rdVal = {19'h0, pcmRx_ff[2]};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setupRd;
      pslverr_ff <= setupRd && !hit;
      prdata_ff <= (setupRd && !pwrite) ? rdVal : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= ctrl_s'(`AP_CTRL_RST);
      slotMap_ff <= `AP_SLOT_RST;
      divN_ff <= `AP_DIV_N_RST;
      divM_ff <= `AP_DIV_M_RST;
      txL_ff <= 16'h0;
      txR_ff <= 16'h0;
      for (int i = 0; i < 3; i++) begin
        pcmTx_ff[i] <= 13'h0;
      end
    end else if (accWr) begin
      case (paddr)
        `AP_CTRL: ctrl_ff <= ctrl_s'(pwdata[16:0]);
        `AP_SLOT: slotMap_ff <= pwdata[11:0];
        `AP_DIV: {divM_ff, divN_ff} <= pwdata;
        `AP_TXL: txL_ff <= pwdata[15:0];
        `AP_TXR: txR_ff <= pwdata[15:0];
        `AP_PTX0: pcmTx_ff[0] <= pwdata[12:0];
        `AP_PTX1: pcmTx_ff[1] <= pwdata[12:0];
        `AP_PTX2: pcmTx_ff[2] <= pwdata[12:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {sckS1_ff, sckS2_ff, sckS3_ff} <= 3'h0;
      {wsS1_ff, wsS2_ff, diS1_ff, diS2_ff} <= 4'h0;
    end else begin
      sckS1_ff <= sckIn;
      sckS2_ff <= sckS1_ff;
      sckS3_ff <= sckS2_ff;
      wsS1_ff <= wsIn;
      wsS2_ff <= wsS1_ff;
      diS1_ff <= diIn;
      diS2_ff <= diS1_ff;
    end
  end

  // ==========================================
  // bit clock: own divider as master, synced pin as slave
  // master bit picks the pin use
  assign run = ctrl_ff.enable;
  assign divSum = {1'b0, divAcc_ff} + {1'b0, divN_ff};
  assign divTick = divSum >= {1'b0, divM_ff};
  // slave edges from pin, needs 2+ clk per half period
  assign sckRise = run && (ctrl_ff.master ? divTick && !sckGen_ff : sckS2_ff && !sckS3_ff);
  assign sckFall = run && (ctrl_ff.master ? divTick && sckGen_ff : !sckS2_ff && sckS3_ff);
  // sync level from own generator or pin
  assign syncLvl = ctrl_ff.master ? wsGen_ff : wsS2_ff;
  assign di = diS2_ff;

  always_ff @(posedge clk) begin
    if (!rst_n || !run || !ctrl_ff.master) begin
      divAcc_ff <= 16'h0;
      sckGen_ff <= 1'b0;
    end else begin
      divAcc_ff <= divTick ? 16'(divSum - {1'b0, divM_ff}) : divSum[15:0];
      if (divTick) sckGen_ff <= !sckGen_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sckOe_ff <= 1'b0;
      wsOe_ff <= 1'b0;
    end else begin
      // clock pins driven only as master
      sckOe_ff <= run && ctrl_ff.master;
      wsOe_ff <= run && ctrl_ff.master;
    end
  end

  // ==========================================
  // frame timing
  // power-of-two slot count
  assign top = frameTop(ctrl_ff.slotsLog);
  assign newIdx = startSeen_ff ? (ctrl_ff.longSync ? 8'h01 : 8'h00) :
                  (bitIdx_ff >= top ? 8'h00 : 8'(bitIdx_ff + 8'h01));
  // separate slot lookups: next index for transmit, current index for receive
  assign hitNew = chHit(newIdx[7:4], ctrl_ff.chEn, slotMap_ff);
  assign hitCur = chHit(bitIdx_ff[7:4], ctrl_ff.chEn, slotMap_ff);

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      bitIdx_ff <= 8'h0;
      {startSeen_ff, syncF_ff, locked_ff, wsGen_ff} <= 4'h0;
      {wsR_ff, wsR2_ff} <= 2'h0;
      i2sCnt_ff <= 4'h0;
    end else if (ctrl_ff.pcm) begin
      if (sckFall) begin
        syncF_ff <= syncLvl;
        if (syncLvl && !syncF_ff) begin
          startSeen_ff <= 1'b1;
          locked_ff <= 1'b1;
        end
      end
      if (sckRise) begin
        bitIdx_ff <= newIdx;
        startSeen_ff <= 1'b0;
        // short pulse in the bit before slot 0
        // long pulse over bits 0 to 2
        if (ctrl_ff.master) begin
          wsGen_ff <= ctrl_ff.longSync ? newIdx < 8'h03 : newIdx == top;
        end
      end
    end else begin
      if (sckRise) begin
        wsR_ff <= syncLvl;
        wsR2_ff <= wsR_ff;
      end
      // ws low for left, toggles every 16 bits
      if (sckFall && ctrl_ff.master) begin
        i2sCnt_ff <= 4'(i2sCnt_ff + 4'h1);
        if (i2sCnt_ff == 4'hf) wsGen_ff <= !wsGen_ff;
      end
    end
  end

  // ==========================================
  // transmit
  assign i2sWord = wsR_ff ? txR_ff : txL_ff;
  assign pcmWord = fmtTx(pcmTx_ff[hitNew[1:0]], ctrl_ff);

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      txSh_ff <= 16'h0;
      doOut_ff <= 1'b0;
      doOe_ff <= 1'b0;
    end else if (!ctrl_ff.pcm) begin
      doOe_ff <= 1'b1;
      if (sckFall) begin
        // load one bit after ws change, on falling edge
        if (wsR_ff != wsR2_ff) begin
          doOut_ff <= i2sWord[15];
          txSh_ff <= {i2sWord[14:0], 1'b0};
        end else begin
          doOut_ff <= txSh_ff[15];
          txSh_ff <= {txSh_ff[14:0], 1'b0};
        end
      end
    end else begin
      if (sckRise) begin
        // drive only in an enabled channel's slot once framed
        if (locked_ff && hitNew[2] && newIdx[3:0] == 4'h0) begin
          doOut_ff <= pcmWord[15];
          txSh_ff <= {pcmWord[14:0], 1'b0};
          doOe_ff <= 1'b1;
        end else begin
          doOut_ff <= txSh_ff[15];
          txSh_ff <= {txSh_ff[14:0], 1'b0};
        end
      end
      // release on falling edge of last bit
      if (sckFall && bitIdx_ff[3:0] == 4'hf) doOe_ff <= 1'b0;
    end
  end

  // ==========================================
  // receive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSh_ff <= 16'h0;
      rxL_ff <= 16'h0;
      rxR_ff <= 16'h0;
      for (int i = 0; i < 3; i++) begin
        pcmRx_ff[i] <= 13'h0;
      end
    end else if (run && !ctrl_ff.pcm && sckRise) begin
      // lsb lands as ws changes; word goes to the old side
      rxSh_ff <= {rxSh_ff[14:0], di};
      if (syncLvl != wsR_ff) begin
        if (wsR_ff) rxR_ff <= {rxSh_ff[14:0], di};
        else rxL_ff <= {rxSh_ff[14:0], di};
      end
    end else if (run && ctrl_ff.pcm && sckFall && locked_ff && hitCur[2]) begin
      rxSh_ff <= {rxSh_ff[14:0], di};
      if (bitIdx_ff[3:0] == 4'hf) begin
        pcmRx_ff[hitCur[1:0]] <= fmtRx({rxSh_ff[14:0], di}, ctrl_ff);
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sckOut = sckGen_ff;
  assign sckOe = sckOe_ff;
  assign wsOut = wsGen_ff;
  assign wsOe = wsOe_ff;
  assign doOut = doOut_ff;
  assign doOe = doOe_ff;

  // ==========================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pcmStart;
    run && ctrl_ff.pcm && startSeen_ff && sckRise;
  endsequence

  property p_i2sDrive;
    (run && !ctrl_ff.pcm) [*2] |-> doOe;
  endproperty
  a_i2sDrive: assert property (p_i2sDrive) else $error("i2s data not driven");

  property p_masterPins;
    run && ctrl_ff.master |=> sckOe && wsOe;
  endproperty
  a_masterPins: assert property (p_masterPins) else $error("master pins idle");

  property p_msbAfterWs;
    run && !ctrl_ff.pcm && sckFall && wsR_ff != wsR2_ff
      |=> doOut == ($past(wsR_ff) ? $past(txR_ff[15]) : $past(txL_ff[15]));
  endproperty
  a_msbAfterWs: assert property (p_msbAfterWs) else $error("msb not launched");

  property p_wsToggle;
    run && !ctrl_ff.pcm && ctrl_ff.master && $changed(wsGen_ff)
      |-> $past(i2sCnt_ff) == 4'hf && $past(sckFall);
  endproperty
  a_wsToggle: assert property (p_wsToggle) else $error("ws toggled off word edge");

  property p_divider;
    run && ctrl_ff.master && $past(run) && $changed(sckGen_ff) |-> $past(divTick);
  endproperty
  a_divider: assert property (p_divider) else $error("bit clock not from divider");

  property p_oeInSlot;
    run && ctrl_ff.pcm && $rose(doOe) |-> bitIdx_ff[3:0] == 4'h0 && hitCur[2];
  endproperty
  a_oeInSlot: assert property (p_oeInSlot) else $error("drive outside own slot");

  property p_release;
    run && ctrl_ff.pcm && $past(run) && $fell(doOe)
      |-> $past(sckFall) && $past(bitIdx_ff[3:0]) == 4'hf;
  endproperty
  a_release: assert property (p_release) else $error("release off last bit");

  property p_shortStart;
    s_pcmStart and !ctrl_ff.longSync |=> bitIdx_ff == 8'h00;
  endproperty
  a_shortStart: assert property (p_shortStart) else $error("short sync misaligned");

  property p_longStart;
    s_pcmStart and ctrl_ff.longSync |=> bitIdx_ff == 8'h01;
  endproperty
  a_longStart: assert property (p_longStart) else $error("long sync misaligned");

  property p_disabled;
    !run |=> !doOe && !sckOe && !wsOe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("outputs driven while off");
endmodule
`default_nettype wire

// >>> testbench/codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic clk, // system clock
  input wire logic gen, // drive bit clock and ws
  input wire logic sckOut, // device bit clock
  input wire logic wsOut, // device ws or sync
  input wire logic doOut, // device data
  input wire logic doOe, // device data drive
  output logic sckIn, // our bit clock
  output logic wsIn, // our ws
  output logic diIn, // data toward device
  output logic [15:0] leftWord, // last left word
  output logic [15:0] rightWord, // last right word
  output logic [15:0] pcmWord, // last pcm word
  output logic [7:0] lCnt, // left words seen
  output logic [7:0] pcmCnt, // pcm words seen
  output logic [5:0] syncLen, // sync width in bits
  output logic [5:0] oeBits // driven bits per frame
);
  logic sck, ws, sPrev = 0, wsPrev = 0, lastDo = 0, oePrev = 0;
  logic [4:0] div = 0;
  logic [3:0] bits = 0, pb = 0;
  logic [15:0] sr = 0, psr = 0;
  logic [5:0] run = 0, oeRun = 0;
  initial {leftWord, rightWord, pcmWord, lCnt, pcmCnt, syncLen, oeBits} = '0;
  assign sck = gen ? sckIn : sckOut;
  assign ws = gen ? wsIn : wsOut;
  // released line shows the inverse of its last level
  assign diIn = doOe ? doOut : ~lastDo;
  always @(posedge clk) if (doOe) lastDo <= doOut;
  // ==========================================
  // clock source, still while not generating
  // 40 clk period, ws flips every 16 bits
  always @(posedge clk) begin
    if (!gen) begin
      div <= 0; bits <= 0; sckIn <= 0; wsIn <= 0;
    end else if (div == 19) begin
      div <= 0;
      sckIn <= ~sckIn;
      if (sckIn) begin
        bits <= bits + 1;
        if (bits == 15) wsIn <= ~wsIn;
      end
    end else div <= div + 1;
  end
  // ==========================================
  // receiver
  always @(posedge clk) begin
    sPrev <= sck;
    // sample on rising edge, word ends when ws flips
    if (sck && !sPrev) begin
      sr <= {sr[14:0], doOut};
      wsPrev <= ws;
      if (ws != wsPrev && wsPrev) rightWord <= {sr[14:0], doOut};
      if (ws != wsPrev && !wsPrev) begin
        leftWord <= {sr[14:0], doOut};
        lCnt <= lCnt + 1;
      end
      if (ws) run <= run + 1;
      else if (run != 0) begin
        syncLen <= run; run <= 0;
      end
      if (ws && !wsPrev) begin
        oeBits <= oeRun; oeRun <= 0;
      end
    end
    // pcm data sampled on falling edge; drive judged before that edge,
    // since the port lets go in the same clock as the last falling edge
    oePrev <= doOe;
    if (!sck && sPrev && oePrev) begin
      psr <= {psr[14:0], doOut};
      oeRun <= oeRun + 1;
      pb <= pb + 1;
      if (pb == 15) begin
        pcmWord <= {psr[14:0], doOut}; pcmCnt <= pcmCnt + 1;
      end
    end else if (!sck && sPrev) begin
      // an idle bit realigns the word counter
      pb <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_port_map.svh"
module tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, gen;
  logic sckIn, sckOut, sckOe, wsIn, wsOut, wsOe, diIn, doOut, doOe;
  logic [7:0] paddr, lCnt, pcmCnt;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] leftWord, rightWord, pcmWord;
  logic [5:0] syncLen, oeBits;
  logic e;
  int err_count = 0, num_checks = 0, cyc = 0, t;
  row_s rows [7] = '{
    '{0, `AP_CTRL, 0, 32'h0, 0}, '{0, `AP_SLOT, 0, 32'h210, 0},
    '{0, `AP_DIV, 0, 32'h186a0020, 0}, '{1, `AP_SLOT, 32'hffffffff, 32'hfff, 0},
    '{1, `AP_RXL, 32'hffff, 32'h0, 0}, '{1, 8'h40, 32'h5, 32'h0, 1},
    '{1, `AP_PTX0, 32'hffffffff, 32'h1fff, 0}};
  audio_serial_port DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .wsIn(wsIn),
    .wsOut(wsOut), .wsOe(wsOe), .diIn(diIn), .doOut(doOut), .doOe(doOe));
  codec_model m (.clk(clk), .gen(gen), .sckOut(sckOut), .wsOut(wsOut), .doOut(doOut),
    .doOe(doOe), .sckIn(sckIn), .wsIn(wsIn), .diIn(diIn), .leftWord(leftWord),
    .rightWord(rightWord), .pcmWord(pcmWord), .lCnt(lCnt), .pcmCnt(pcmCnt),
    .syncLen(syncLen), .oeBits(oeBits));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic summarize;
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // no wait count assumed; the bench timeout ends a hung transfer
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic waitEv(input bit pcm, input int n);
    int b;
    b = pcm ? pcmCnt : lCnt;
    do @(posedge clk); while ((pcm ? int'(pcmCnt) : int'(lCnt)) < b + n);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end
  // ==========================================
  // sequence
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; gen = 0;
    repeat (16) @(posedge clk);
    chk({sckOe, wsOe, doOe}, 0);
    rst_n <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk(q, rows[i].e);
      chk(e, rows[i].r);
    end
    // i2s master at 12.5 MHz bit clock
    apb(1, `AP_DIV, 32'h00040001);
    apb(1, `AP_TXL, 32'ha5c3);
    apb(1, `AP_TXR, 32'h3c5a);
    apb(1, `AP_CTRL, 32'h5);
    waitEv(0, 3);
    chk({sckOe, wsOe, doOe}, 3'h7);
    chk(leftWord, 16'ha5c3);
    chk(rightWord, 16'h3c5a);
    @(posedge sckOut);
    t = cyc;
    @(posedge sckOut);
    chk(cyc - t, 8);
    apb(0, `AP_RXL, 0);
    chk(q, 32'ha5c3);
    // pcm master, two slots, channel 0 in slot 0
    apb(1, `AP_CTRL, 0);
    apb(1, `AP_SLOT, 32'h210);
    apb(1, `AP_PTX0, 32'h1abc);
    apb(1, `AP_CTRL, 32'h4807);
    waitEv(1, 3);
    chk(pcmWord, 16'hd5e0);
    chk(oeBits, 16);
    chk(syncLen, 1);
    apb(0, `AP_PRX0, 0);
    chk(q, 32'h1abc);
    apb(0, `AP_STAT, 0);
    chk(q[10], 1'b1);
    apb(1, `AP_CTRL, 32'h480f);
    waitEv(1, 3);
    chk(syncLen, 3);
    // every fill mode, fill value 5
    for (int f = 0; f < 4; f++) begin
      apb(1, `AP_CTRL, 32'h4947 | (f << 4));
      waitEv(1, 3);
      chk(pcmWord[2:0], f == 3 ? 3'h5 : (f == 0 ? 3'h0 : 3'h7));
    end
    // right justified, lsb first: zero fill ends up on the far end
    apb(1, `AP_CTRL, 32'h4e07);
    waitEv(1, 3);
    chk(pcmWord, 16'h3d58);
    apb(0, `AP_PRX0, 0);
    chk(q, 32'h1abc);
    // i2s slave, model makes a 2.5 MHz clock
    apb(1, `AP_CTRL, 0);
    apb(1, `AP_CTRL, 32'h1);
    gen <= 1;
    waitEv(0, 3);
    chk({sckOe, wsOe, doOe}, 3'h1);
    chk(leftWord, 16'ha5c3);
    // pcm slave on the model's clock; its word select rise is the sync
    apb(1, `AP_CTRL, 0);
    apb(1, `AP_CTRL, 32'h4803);
    waitEv(1, 4);
    chk({sckOe, wsOe}, 2'h0);
    chk(pcmWord, 16'hd5e0);
    // reset in mid-run: pins released, control back to off
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({sckOe, wsOe, doOe}, 0);
    apb(0, `AP_CTRL, 0);
    chk(q, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
